//--- fpskr_regs.sv
// flash routine select, protection key and array select registers on wishbone
//
// Implementation choices: register access over Wishbone and the placing of the registers.
`timescale 1ns/1ns
`include "fpskr_defines.svh"

module fpskr_regs
	import fpskr_pkg::*;
(
	// clock and reset
	input  wire logic                        clk_sys_i,
	input  wire logic                        reset_n_i,
	// classic wishbone slave
	input  wire logic                        wb_cyc_i,
	input  wire logic                        wb_stb_i,
	input  wire logic                        wb_we_i,
	input  wire logic [`FPSKR_ADR_W-1:0]     wb_adr_i,
	input  wire logic [3:0]                  wb_sel_i,
	input  wire logic [31:0]                 wb_dat_i,
	output wire logic [31:0]                 wb_dat_o,
	output wire logic                        wb_ack_o,
	// cpu and mode status
	input  wire logic                        exec_from_ram_i,
	input  wire logic                        ram_emulation_on_i,
	input  wire logic                        user_boot_mode_i,
	input  wire logic [`FPSKR_DEST_W-1:0]    download_destination_i,
	// flash control
	output wire logic                        flash_modify_enable_o,
	output wire logic                        user_boot_array_sel_o,
	output wire logic                        download_busy_o,
	// routine rom
	output wire logic [`FPSKR_ROM_ADR_W-1:0] rom_addr_o,
	input  wire logic [31:0]                 rom_data_i,
	// on-chip ram write port
	output wire logic                        ram_we_o,
	output wire logic [`FPSKR_RAM_ADR_W-1:0] ram_addr_o,
	output wire logic [31:0]                 ram_wdata_o
);

	// register state
	logic                   program_routine_sel_bit_reg;
	logic                   erase_routine_sel_bit_reg;
	fpskr_byte_t            protection_key_reg;
	fpskr_byte_t            flash_array_select_reg;
	logic                   download_request_reg;
	logic                   refused_reg;
	logic                   strap_done_reg;
	logic                   ack_reg;
	logic [31:0]            rdata_reg;
	logic                   modify_en_reg;
	logic                   boot_sel_reg;

	// next values
	logic                   program_routine_sel_bit_next;
	logic                   erase_routine_sel_bit_next;
	fpskr_byte_t            flash_array_select_next;
	logic                   download_request_next;
	logic                   refused_next;
	logic [31:0]            rdata_next;

	// link to the download engine
	fpskr_dl_if             dl_link ();

	// bus decode
	wire logic              bus_req     = wb_cyc_i && wb_stb_i;
	wire logic              bus_fire    = bus_req && ack_reg;
	wire logic              lane0_wr    = bus_fire && wb_we_i && wb_sel_i[0];
	wire logic              hit_prog    = (wb_adr_i == `FPSKR_OFS_PROG_SEL);
	wire logic              hit_erase   = (wb_adr_i == `FPSKR_OFS_ERASE_SEL);
	wire logic              hit_key     = (wb_adr_i == `FPSKR_OFS_KEY);
	wire logic              hit_array   = (wb_adr_i == `FPSKR_OFS_ARRAY_SEL);
	wire logic              hit_ctrl    = (wb_adr_i == `FPSKR_OFS_DL_CTRL);
	wire fpskr_byte_t       wr_byte     = wb_dat_i[7:0];

	// per-register write strobes
	wire logic              wr_prog     = lane0_wr && hit_prog;
	wire logic              wr_erase    = lane0_wr && hit_erase;
	wire logic              wr_key      = lane0_wr && hit_key;
	wire logic              wr_array    = lane0_wr && hit_array;
	wire logic              wr_ctrl     = lane0_wr && hit_ctrl;

	// key comparison, live on the stored byte
	wire logic              key_download_ok =
		(protection_key_reg == `FPSKR_KEY_DOWNLOAD);
	wire logic              key_program_ok  =
		(protection_key_reg == `FPSKR_KEY_PROGRAM);

	// download request qualification
	wire logic              req_written  = wr_ctrl && wr_byte[`FPSKR_CTRL_REQ_BIT];
	wire logic              req_allowed  = key_download_ok && exec_from_ram_i
		&& !ram_emulation_on_i && !download_request_reg;
	wire logic              req_accept   = req_written && req_allowed;
	wire logic              req_refuse   = req_written && !req_allowed;
	wire logic              refused_clr  = wr_ctrl && wr_byte[`FPSKR_CTRL_REFUSED_BIT];

	// array select write only while fetching from ram
	wire logic              array_wr_ok  = wr_array && exec_from_ram_i;
	wire fpskr_byte_t       strap_value  =
		user_boot_mode_i ? `FPSKR_ARRAY_USER_BOOT : `FPSKR_ARRAY_USER;

	// transfer completion from the engine
	wire logic              dl_done      = dl_link.done;

	// readback words; narrow registers sit in the low byte
	wire logic [31:0]       rd_prog  = {31'h0, program_routine_sel_bit_reg};
	wire logic [31:0]       rd_erase = {31'h0, erase_routine_sel_bit_reg};
	wire logic [31:0]       rd_key   = {24'h0, protection_key_reg};
	wire logic [31:0]       rd_array = {24'h0, flash_array_select_reg};
	wire logic [31:0]       rd_ctrl  = {28'h0, refused_reg, key_program_ok,
		key_download_ok, download_request_reg};

	// outputs
	assign wb_ack_o              = ack_reg;
	assign wb_dat_o              = rdata_reg;
	assign flash_modify_enable_o = modify_en_reg;
	assign user_boot_array_sel_o = boot_sel_reg;
	assign download_busy_o       = download_request_reg;

	// engine control; selections are read live while the copy starts
	assign dl_link.start     = download_request_reg && !dl_link.busy && !dl_link.done;
	assign dl_link.prog_sel  = program_routine_sel_bit_reg;
	assign dl_link.erase_sel = erase_routine_sel_bit_reg;
	assign dl_link.dest      = download_destination_i;

	// select bits: a software write in the completion cycle is newer, so it wins
	always_comb begin
		program_routine_sel_bit_next = program_routine_sel_bit_reg;
		erase_routine_sel_bit_next   = erase_routine_sel_bit_reg;
		if (dl_done) begin
			program_routine_sel_bit_next = 1'b0;
			erase_routine_sel_bit_next   = 1'b0;
		end
		if (wr_prog) begin
			program_routine_sel_bit_next = wr_byte[`FPSKR_SEL_BIT];
		end
		if (wr_erase) begin
			erase_routine_sel_bit_next = wr_byte[`FPSKR_SEL_BIT];
		end
	end

	// array select: strap load once after reset, then ram-only writes
	always_comb begin
		flash_array_select_next = flash_array_select_reg;
		if (!strap_done_reg) begin
			flash_array_select_next = strap_value;
		end
		if (array_wr_ok) begin
			flash_array_select_next = wr_byte;
		end
	end

	// download request and refusal flag; set beats clear on the flag
	always_comb begin
		download_request_next = download_request_reg;
		refused_next          = refused_reg;
		if (dl_done) begin
			download_request_next = 1'b0;
		end
		if (req_accept) begin
			download_request_next = 1'b1;
		end
		if (refused_clr) begin
			refused_next = 1'b0;
		end
		if (req_refuse) begin
			refused_next = 1'b1;
		end
	end

	// read mux; unmapped offsets read zero
	always_comb begin
		rdata_next = 32'h0;
		if (hit_prog) begin
			rdata_next = rd_prog;
		end else if (hit_erase) begin
			rdata_next = rd_erase;
		end else if (hit_key) begin
			rdata_next = rd_key;
		end else if (hit_array) begin
			rdata_next = rd_array;
		end else if (hit_ctrl) begin
			rdata_next = rd_ctrl;
		end
	end

	// bus handshake: ack one cycle after the request, dropped the cycle after
	always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			ack_reg   <= 1'b0;
			rdata_reg <= 32'h0;
		end else begin
			ack_reg   <= bus_req && !ack_reg;
			rdata_reg <= rdata_next;
		end
	end

	// routine select bits
	always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			program_routine_sel_bit_reg <= 1'b0;
			erase_routine_sel_bit_reg   <= 1'b0;
		end else begin
			program_routine_sel_bit_reg <= program_routine_sel_bit_next;
			erase_routine_sel_bit_reg   <= erase_routine_sel_bit_next;
		end
	end

	// key register takes any byte; gating follows one cycle later
	always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			protection_key_reg <= `FPSKR_RST_BYTE;
		end else if (wr_key) begin
			protection_key_reg <= wr_byte;
		end
	end

	// array select; the strap is caught after release, never by the reset itself
	always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			flash_array_select_reg <= `FPSKR_RST_BYTE;
			strap_done_reg         <= 1'b0;
		end else begin
			flash_array_select_reg <= flash_array_select_next;
			strap_done_reg         <= 1'b1;
		end
	end

	// download request and refusal flag
	always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			download_request_reg <= 1'b0;
			refused_reg          <= 1'b0;
		end else begin
			download_request_reg <= download_request_next;
			refused_reg          <= refused_next;
		end
	end

	// flash side outputs registered to keep glitches off the array switch
	always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			modify_en_reg <= 1'b0;
			boot_sel_reg  <= 1'b0;
		end else begin
			modify_en_reg <= key_program_ok;
			boot_sel_reg  <= (flash_array_select_next == `FPSKR_ARRAY_USER_BOOT);
		end
	end

	// copy engine
	fpskr_download u_download (
		.clk_sys_i   (clk_sys_i),
		.reset_n_i   (reset_n_i),
		.dl          (dl_link.engine),
		.rom_addr_o  (rom_addr_o),
		.rom_data_i  (rom_data_i),
		.ram_we_o    (ram_we_o),
		.ram_addr_o  (ram_addr_o),
		.ram_wdata_o (ram_wdata_o)
	);

endmodule : fpskr_regs

//--- fpskr_defines.svh
// register offsets, field positions, key values and sizes of the flash select and key block
`ifndef FPSKR_DEFINES_SVH
`define FPSKR_DEFINES_SVH

// wishbone byte offsets, one aligned word per register
`define FPSKR_ADR_W            8
`define FPSKR_OFS_PROG_SEL     8'h00
`define FPSKR_OFS_ERASE_SEL    8'h04
`define FPSKR_OFS_KEY          8'h08
`define FPSKR_OFS_ARRAY_SEL    8'h0c
`define FPSKR_OFS_DL_CTRL      8'h10

// field positions
`define FPSKR_SEL_BIT          0
`define FPSKR_CTRL_REQ_BIT     0
`define FPSKR_CTRL_KEYDL_BIT   1
`define FPSKR_CTRL_KEYPE_BIT   2
`define FPSKR_CTRL_REFUSED_BIT 3

// key and array select values
`define FPSKR_KEY_DOWNLOAD     8'ha5
`define FPSKR_KEY_PROGRAM      8'h5a
`define FPSKR_ARRAY_USER_BOOT  8'haa
`define FPSKR_ARRAY_USER       8'h00

// reset values
`define FPSKR_RST_BYTE         8'h00

// download engine sizing
`define FPSKR_ROUTINE_WORDS    16
`define FPSKR_IDX_W            4
`define FPSKR_DEST_W           3
`define FPSKR_RAM_ADR_W        15
`define FPSKR_ROM_ADR_W        5
`define FPSKR_IDX_LAST         4'hf

`endif

//--- fpskr_pkg.sv
// types shared by the flash select and key block
package fpskr_pkg;

	typedef logic [7:0] fpskr_byte_t;

	// download engine states
	typedef enum logic [1:0] {
		FPSKR_DL_IDLE,
		FPSKR_DL_COPY,
		FPSKR_DL_FINISH
	} fpskr_dl_state_e;

endpackage : fpskr_pkg

//--- fpskr_dl_if.sv
// carrier between the register file and the download engine
`timescale 1ns/1ns
`include "fpskr_defines.svh"

interface fpskr_dl_if;
	logic                      start;
	logic                      prog_sel;
	logic                      erase_sel;
	logic [`FPSKR_DEST_W-1:0]  dest;
	logic                      busy;
	logic                      done;

	modport ctrl (
		output start,
		output prog_sel,
		output erase_sel,
		output dest,
		input  busy,
		input  done
	);

	modport engine (
		input  start,
		input  prog_sel,
		input  erase_sel,
		input  dest,
		output busy,
		output done
	);
endinterface : fpskr_dl_if

//--- fpskr_download.sv
// download engine: copies the selected internal routine into on-chip ram
`timescale 1ns/1ns
`include "fpskr_defines.svh"

module fpskr_download
	import fpskr_pkg::*;
(
	// clock and reset
	input  wire logic                        clk_sys_i,
	input  wire logic                        reset_n_i,
	// control from the register file
	fpskr_dl_if.engine                       dl,
	// routine rom, combinational read
	output wire logic [`FPSKR_ROM_ADR_W-1:0] rom_addr_o,
	input  wire logic [31:0]                 rom_data_i,
	// on-chip ram write port
	output wire logic                        ram_we_o,
	output wire logic [`FPSKR_RAM_ADR_W-1:0] ram_addr_o,
	output wire logic [31:0]                 ram_wdata_o
);

	fpskr_dl_state_e                state_reg;
	fpskr_dl_state_e                state_next;
	logic [`FPSKR_IDX_W-1:0]        idx_reg;
	logic                           erase_reg;
	logic [`FPSKR_DEST_W-1:0]       dest_reg;
	logic                           we_reg;
	logic [`FPSKR_RAM_ADR_W-1:0]    waddr_reg;
	logic [31:0]                    wdata_reg;

	wire logic                      nothing_sel = !dl.prog_sel && !dl.erase_sel;
	wire logic                      last_word   = (idx_reg == `FPSKR_IDX_LAST);
	// 4 KB block base plus word offset; the offset never carries into the base
	wire logic [`FPSKR_RAM_ADR_W-1:0] word_addr =
		{dest_reg, {(`FPSKR_RAM_ADR_W-`FPSKR_DEST_W-`FPSKR_IDX_W-2){1'b0}}, idx_reg, 2'b00};

	// rom word index; upper bit picks the erase routine
	assign rom_addr_o  = {erase_reg, idx_reg};
	assign ram_we_o    = we_reg;
	assign ram_addr_o  = waddr_reg;
	assign ram_wdata_o = wdata_reg;
	assign dl.busy     = (state_reg != FPSKR_DL_IDLE);
	assign dl.done     = (state_reg == FPSKR_DL_FINISH);

	// next state; with no routine selected the transfer finishes at once
	always_comb begin
		state_next = state_reg;
		case (state_reg)
			FPSKR_DL_IDLE: begin
				if (dl.start) begin
					state_next = nothing_sel ? FPSKR_DL_FINISH : FPSKR_DL_COPY;
				end
			end
			FPSKR_DL_COPY: begin
				if (last_word) begin
					state_next = FPSKR_DL_FINISH;
				end
			end
			FPSKR_DL_FINISH: state_next = FPSKR_DL_IDLE;
			default:         state_next = FPSKR_DL_IDLE;
		endcase
	end

	// one word per cycle, registered towards the ram
	always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			state_reg <= FPSKR_DL_IDLE;
			idx_reg   <= '0;
			erase_reg <= 1'b0;
			dest_reg  <= '0;
			we_reg    <= 1'b0;
			waddr_reg <= '0;
			wdata_reg <= '0;
		end else begin
			state_reg <= state_next;
			we_reg    <= (state_reg == FPSKR_DL_COPY);
			if (state_reg == FPSKR_DL_IDLE) begin
				idx_reg   <= '0;
				erase_reg <= !dl.prog_sel; // programming routine wins if both chosen
				dest_reg  <= dl.dest;
			end else if (state_reg == FPSKR_DL_COPY) begin
				idx_reg   <= idx_reg + 1'b1;
				waddr_reg <= word_addr;
				wdata_reg <= rom_data_i;
			end
		end
	end

endmodule : fpskr_download

//--- fpskr_regs_asserts.sv
// concurrent checks on the ports of the flash select and key register block
`timescale 1ns/1ns
`include "fpskr_defines.svh"

module fpskr_regs_asserts (
	// clock and reset
	input wire logic                        clk_sys_i,
	input wire logic                        reset_n_i,
	// wishbone
	input wire logic                        wb_cyc_i,
	input wire logic                        wb_stb_i,
	input wire logic                        wb_we_i,
	input wire logic [`FPSKR_ADR_W-1:0]     wb_adr_i,
	input wire logic [3:0]                  wb_sel_i,
	input wire logic [31:0]                 wb_dat_i,
	input wire logic [31:0]                 wb_dat_o,
	input wire logic                        wb_ack_o,
	// status and flash control
	input wire logic                        exec_from_ram_i,
	input wire logic                        ram_emulation_on_i,
	input wire logic                        user_boot_mode_i,
	input wire logic                        flash_modify_enable_o,
	input wire logic                        user_boot_array_sel_o,
	input wire logic                        download_busy_o,
	// ram port
	input wire logic                        ram_we_o,
	input wire logic [`FPSKR_RAM_ADR_W-1:0] ram_addr_o
);
	default clocking cb @(posedge clk_sys_i); endclocking
	default disable iff (!reset_n_i);

	// decoded accepted writes at the ack edge
	wire       wr_any = wb_cyc_i && wb_stb_i && wb_ack_o && wb_we_i && wb_sel_i[0];
	wire       key_wr = wr_any && (wb_adr_i == `FPSKR_OFS_KEY);
	wire       arr_wr = wr_any && (wb_adr_i == `FPSKR_OFS_ARRAY_SEL) && exec_from_ram_i;
	wire       req_wr = wr_any && (wb_adr_i == `FPSKR_OFS_DL_CTRL) && wb_dat_i[0];
	logic [7:0] key_sh, arr_sh;
	logic       key_wr_d, arr_wr_d;
	logic [1:0] edge_cnt;
	logic [4:0] we_run;
	wire        req_ok = (key_sh == `FPSKR_KEY_DOWNLOAD) && exec_from_ram_i && !ram_emulation_on_i;

	// shadow copies of key and array select; strap taken on first edge after release
	always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			key_sh   <= 8'h00;
			arr_sh   <= 8'h00;
			key_wr_d <= 1'b0;
			arr_wr_d <= 1'b0;
			edge_cnt <= 2'h0;
			we_run   <= 5'h00;
		end else begin
			key_sh   <= key_wr ? wb_dat_i[7:0] : key_sh;
			arr_sh   <= (edge_cnt == 2'h0) ? (user_boot_mode_i ? 8'haa : 8'h00)
				: (arr_wr ? wb_dat_i[7:0] : arr_sh);
			key_wr_d <= key_wr;
			arr_wr_d <= arr_wr;
			edge_cnt <= (edge_cnt == 2'h3) ? edge_cnt : edge_cnt + 2'h1;
			we_run   <= ram_we_o ? we_run + 5'h01 : 5'h00; // run length of copy strobes
		end
	end

	a_ack_single: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o)
		else $error("ack not a single pulse one cycle after request");
	a_sel_upper_zero: assert property (wb_ack_o && !wb_we_i &&
		(wb_adr_i == `FPSKR_OFS_PROG_SEL || wb_adr_i == `FPSKR_OFS_ERASE_SEL)
		|-> wb_dat_o[31:1] == 31'h0) else $error("select register upper bits not zero");
	a_key_modify_gate: assert property (!key_wr && !key_wr_d
		|-> flash_modify_enable_o == (key_sh == `FPSKR_KEY_PROGRAM))
		else $error("flash modify enable disagrees with key");
	a_array_sel_map: assert property (edge_cnt == 2'h3
		&& !arr_wr && !arr_wr_d
		|-> user_boot_array_sel_o == (arr_sh == `FPSKR_ARRAY_USER_BOOT))
		else $error("user boot array select disagrees with array select value");
	a_req_refused: assert property (req_wr && !req_ok && !download_busy_o
		|=> !download_busy_o) else $error("download request accepted without its conditions");
	a_req_accepted: assert property (req_wr && req_ok && !download_busy_o
		|=> download_busy_o) else $error("download request not accepted");
	a_copy_count: assert property ($fell(ram_we_o)
		|-> we_run == 5'h10 && !download_busy_o)
		else $error("copy length not sixteen words or request not cleared");
	a_copy_busy: assert property (ram_we_o |-> download_busy_o)
		else $error("ram write outside a download");
	a_copy_addr_step: assert property (ram_we_o && $past(ram_we_o)
		|-> ram_addr_o == $past(ram_addr_o) + 15'h0004) else $error("ram address step not four");

	c_req_ok: cover property (req_wr && req_ok);
	c_req_bad: cover property (req_wr && !req_ok);
	c_copy: cover property ($fell(ram_we_o));
	c_arr_wr: cover property (arr_wr);
endmodule : fpskr_regs_asserts

bind fpskr_regs fpskr_regs_asserts u_asserts (.*);

//--- tb_flash_program_select_and_key_regs.sv
// self-checking testbench of the flash select and key register block
`timescale 1ns/1ns
`include "fpskr_defines.svh"

module tb_flash_program_select_and_key_regs;
	import fpskr_pkg::*;

	typedef struct {
		logic [7:0] adr;
		logic [7:0] wd;
		logic [7:0] rd;
		logic       fme;
		logic       ubs;
	} fpskr_row_s;
	logic [3:0]  wr_sel = 4'h1;
	logic        clk_sys_i, reset_n_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
	logic [7:0]  wb_adr_i;
	logic [3:0]  wb_sel_i;
	logic [31:0] wb_dat_i, wb_dat_o, rom_data_i, ram_wdata_o, rdat;
	logic        exec_from_ram_i, ram_emulation_on_i, user_boot_mode_i;
	logic [2:0]  download_destination_i;
	logic        flash_modify_enable_o, user_boot_array_sel_o, download_busy_o, ram_we_o;
	logic [4:0]  rom_addr_o;
	logic [14:0] ram_addr_o;
	int          bad_count = 0;
	int          compares = 0;
	fpskr_row_s  rows [9] = '{
		'{`FPSKR_OFS_PROG_SEL, 8'hff, 8'h01, 1'b0, 1'b0},
		'{`FPSKR_OFS_ERASE_SEL, 8'hfe, 8'h00, 1'b0, 1'b0},
		'{`FPSKR_OFS_ERASE_SEL, 8'hff, 8'h01, 1'b0, 1'b0},
		'{`FPSKR_OFS_KEY, 8'h5a, 8'h5a, 1'b1, 1'b0},
		'{`FPSKR_OFS_KEY, 8'ha5, 8'ha5, 1'b0, 1'b0},
		'{`FPSKR_OFS_ARRAY_SEL, 8'haa, 8'haa, 1'b0, 1'b1},
		'{`FPSKR_OFS_ARRAY_SEL, 8'hab, 8'hab, 1'b0, 1'b0},
		'{`FPSKR_OFS_ARRAY_SEL, 8'haa, 8'haa, 1'b0, 1'b1},
		'{8'h14, 8'hff, 8'h00, 1'b0, 1'b1}};

	// rom answers combinationally with a tag of its own address
	assign rom_data_i = {27'h2d5a000, rom_addr_o};

	fpskr_regs dut (.clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i), .wb_cyc_i(wb_cyc_i),
		.wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
		.wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
		.exec_from_ram_i(exec_from_ram_i), .ram_emulation_on_i(ram_emulation_on_i),
		.user_boot_mode_i(user_boot_mode_i), .download_destination_i(download_destination_i),
		.flash_modify_enable_o(flash_modify_enable_o), .user_boot_array_sel_o(user_boot_array_sel_o),
		.download_busy_o(download_busy_o), .rom_addr_o(rom_addr_o), .rom_data_i(rom_data_i),
		.ram_we_o(ram_we_o), .ram_addr_o(ram_addr_o), .ram_wdata_o(ram_wdata_o));

	// clock at 50 ns period
	initial begin
		clk_sys_i = 1'b0;
		forever #25 clk_sys_i = ~clk_sys_i;
	end

	task chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			bad_count++;
			$display("ERROR %s expected %h seen %h", name, exp, seen);
		end
	endtask : chk

	// one classic cycle; held until ack is sampled, released at that edge
	task wb(input logic we, input logic [7:0] adr, input logic [7:0] d);
		int n;
		@(posedge clk_sys_i);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i  <= we;
		wb_sel_i <= wr_sel;
		wb_adr_i <= adr;
		wb_dat_i <= {24'h000000, d};
		n = 0;
		do begin
			@(posedge clk_sys_i);
			n++;
		end while (wb_ack_o !== 1'b1 && n < 20);
		rdat = wb_dat_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		wb_we_i  <= 1'b0;
		if (n >= 20) chk("ack wait", 32'h0, 32'h1);
	endtask : wb

	task rd(input logic [7:0] adr, input logic [7:0] exp);
		wb(1'b0, adr, 8'h00);
		chk("read data", rdat, {24'h000000, exp});
	endtask : rd

	// selects, destination, request, then watch the ram port for 30 cycles
	task dl(input logic [7:0] ps, input logic [7:0] es, input logic [2:0] dst, input int exp_n);
		int n;
		logic er;
		er = ~ps[0];
		wb(1'b1, `FPSKR_OFS_PROG_SEL, ps);
		wb(1'b1, `FPSKR_OFS_ERASE_SEL, es);
		download_destination_i <= dst;
		wb(1'b1, `FPSKR_OFS_DL_CTRL, 8'h01);
		n = 0;
		repeat (30) begin
			@(posedge clk_sys_i);
			if (ram_we_o === 1'b1) begin
				chk("ram addr", {17'h0, ram_addr_o}, dst * 4096 + n * 4);
				chk("ram data", ram_wdata_o, {27'h2d5a000, er, n[3:0]});
				n++;
			end
		end
		chk("word count", n, exp_n);
		rd(`FPSKR_OFS_PROG_SEL, 8'h00);
		rd(`FPSKR_OFS_ERASE_SEL, 8'h00);
	endtask : dl

	// try a request under the present conditions; it must be refused
	task refuse(input logic [7:0] ctrl_exp);
		wb(1'b1, `FPSKR_OFS_DL_CTRL, 8'h01);
		rd(`FPSKR_OFS_DL_CTRL, ctrl_exp);
		chk("busy", download_busy_o, 1'b0);
		wb(1'b1, `FPSKR_OFS_DL_CTRL, 8'h08);
	endtask : refuse

	task test_done;
		$display("comparisons %0d mismatches %0d", compares, bad_count);
		if (bad_count == 0 && compares > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : test_done

	// watchdog well beyond the few hundred cycles the tests take
	initial begin
		#(50 * 20000);
		bad_count++;
		test_done;
	end

	initial begin
		reset_n_i = 1'b0;
		{wb_cyc_i, wb_stb_i, wb_we_i, ram_emulation_on_i, user_boot_mode_i} = 5'h00;
		wb_adr_i = 8'h00;
		wb_sel_i = 4'h1;
		wb_dat_i = 32'h0;
		exec_from_ram_i = 1'b1;
		download_destination_i = 3'h0;
		repeat (12) @(posedge clk_sys_i);
		reset_n_i <= 1'b1;
		rd(`FPSKR_OFS_PROG_SEL, 8'h00);
		rd(`FPSKR_OFS_ERASE_SEL, 8'h00);
		rd(`FPSKR_OFS_KEY, 8'h00);
		rd(`FPSKR_OFS_ARRAY_SEL, 8'h00);
		// ordinary writes with read back and output levels
		foreach (rows[i]) begin
			wb(1'b1, rows[i].adr, rows[i].wd);
			rd(rows[i].adr, rows[i].rd);
			chk("modify enable", flash_modify_enable_o, rows[i].fme);
			chk("boot array", user_boot_array_sel_o, rows[i].ubs);
		end
		// a write without the low byte lane leaves the key alone
		wr_sel = 4'he;
		wb(1'b1, `FPSKR_OFS_KEY, 8'h33);
		wr_sel = 4'h1;
		rd(`FPSKR_OFS_KEY, 8'ha5);
		// array select refused while running from flash
		exec_from_ram_i <= 1'b0;
		wb(1'b1, `FPSKR_OFS_ARRAY_SEL, 8'h00);
		rd(`FPSKR_OFS_ARRAY_SEL, 8'haa);
		chk("boot array", user_boot_array_sel_o, 1'b1);
		// refused requests: wrong key twice, flash execution, emulation on
		wb(1'b1, `FPSKR_OFS_KEY, 8'h00);
		exec_from_ram_i <= 1'b1;
		refuse(8'h08);
		wb(1'b1, `FPSKR_OFS_KEY, 8'h5a);
		refuse(8'h0c);
		wb(1'b1, `FPSKR_OFS_KEY, 8'ha5);
		exec_from_ram_i <= 1'b0;
		refuse(8'h0a);
		exec_from_ram_i <= 1'b1;
		ram_emulation_on_i <= 1'b1;
		refuse(8'h0a);
		ram_emulation_on_i <= 1'b0;
		// accepted downloads: programming wins over erase, erase alone, nothing selected
		dl(8'h01, 8'h01, 3'h3, 16);
		dl(8'h00, 8'h01, 3'h7, 16);
		dl(8'h00, 8'h00, 3'h5, 0);
		rd(`FPSKR_OFS_DL_CTRL, 8'h02);
		// second reset started in user-boot mode
		reset_n_i <= 1'b0;
		user_boot_mode_i <= 1'b1;
		repeat (2) @(posedge clk_sys_i);
		reset_n_i <= 1'b1;
		rd(`FPSKR_OFS_KEY, 8'h00);
		rd(`FPSKR_OFS_ARRAY_SEL, 8'haa);
		chk("boot array", user_boot_array_sel_o, 1'b1);
		test_done;
	end
endmodule : tb_flash_program_select_and_key_regs
